//--- otis_defines.svh
// Constants for the two-wire slave of the OTG transceiver.
// Assumes a 25 MHz core clock; included by the design modules and the testbench.
`ifndef OTIS_DEFINES_SVH
`define OTIS_DEFINES_SVH

// Upper six bits of the slave address, fixed in silicon.
`define OTIS_ADDR_HIGH 6'h16
// Address byte that selects every slave at once.
`define OTIS_GENERAL_CALL 8'h00
// Number of register indices that answer with an acknowledge.
`define OTIS_NUM_REGS 8'h20
// Write path buffer shape: index and data side by side.
`define OTIS_FIFO_DEPTH 32
`define OTIS_FIFO_WIDTH 16
// Pins rest high, so the synchroniser starts high too.
`define OTIS_SYNC_RESET 3'h7
// Cycles after reset before the strap pin is trusted.
`define OTIS_STRAP_WAIT 3'h6
// Data bits in a byte before the acknowledge slot.
`define OTIS_BITS_PER_BYTE 4'h8
// Core clock period and the fastest serial clock supported.
`define OTIS_CLK_PERIOD_NS 40
`define OTIS_SCL_MAX_KHZ 400
`define OTIS_SCL_HALF_NS (1000000 / (2 * `OTIS_SCL_MAX_KHZ))
`define OTIS_SCL_HALF_CYC \
  ((`OTIS_SCL_HALF_NS + `OTIS_CLK_PERIOD_NS - 1) / `OTIS_CLK_PERIOD_NS)

`endif

//--- otis_pkg.sv
// Types shared by the two-wire slave modules.
// Assumes nothing of its surroundings.
package otis_pkg;

  // Phases of the serial slave.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_INDEX,
    ST_WRITE,
    ST_ACK,
    ST_READ,
    ST_MACK,
    ST_IGNORE
  } otis_state_type;

endpackage : otis_pkg

//--- otis_pin_sync.sv
// Synchroniser with glitch filter for pins from outside the core clock.
// Assumes the pins are asynchronous to core_clk.
`timescale 1ns/100ps
`include "otis_defines.svh"
module otis_pin_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = `OTIS_SYNC_RESET
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  // Three stage flops and an output flop per pin; a level is taken only when the last two stages agree,
  // which hides a one-cycle glitch at the cost of one cycle of delay.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : gBit
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          stage1_reg[i] <= RESET_VAL[i];
          stage2_reg[i] <= RESET_VAL[i];
          stage3_reg[i] <= RESET_VAL[i];
          pinOut[i] <= RESET_VAL[i];
        end else begin
          stage1_reg[i] <= pinIn[i];
          stage2_reg[i] <= stage1_reg[i];
          stage3_reg[i] <= stage2_reg[i];
          if (stage2_reg[i] == stage3_reg[i]) begin
            pinOut[i] <= stage3_reg[i];
          end
        end
      end
    end
  endgenerate

endmodule : otis_pin_sync

//--- otis_fifo.sv
// First-in first-out buffer of flip-flops with valid/ready on both sides.
// Assumes DEPTH is a power of two and both sides share core_clk.
`timescale 1ns/100ps
`include "otis_defines.svh"
module otis_fifo #(
  parameter int WIDTH = `OTIS_FIFO_WIDTH,
  parameter int DEPTH = `OTIS_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0] count_reg;
  logic doPush;
  logic doPop;
  logic [AW-1:0] headNext;
  logic [AW:0] countNext;
  logic outValid_reg;
  logic [WIDTH-1:0] outData_reg;

  // Full and empty come from the occupancy count, never guessed.
  assign inReady = (count_reg != (AW+1)'(DEPTH));
  assign outValid = outValid_reg;
  assign outData = outData_reg;
  assign doPush = inValid && inReady;
  assign doPop = outValid_reg && outReady;
  assign headNext = doPop ? rdPtr_reg + 1'b1 : rdPtr_reg;

  // Occupancy after this edge; it also decides the registered valid.
  always_comb begin
    countNext = count_reg;
    if (doPush && !doPop) begin
      countNext = count_reg + 1'b1;
    end else if (doPop && !doPush) begin
      countNext = count_reg - 1'b1;
    end
  end

  // The head is kept in flops so the outputs carry no read mux. A push
  // into an empty buffer must bypass storage, which is written too late.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      outValid_reg <= 1'b0;
      outData_reg <= '0;
    end else begin
      outValid_reg <= (countNext != '0);
      if (doPush && wrPtr_reg == headNext) begin
        outData_reg <= inData;
      end else begin
        outData_reg <= mem[headNext];
      end
    end
  end

  // Storage is not reset; only valid entries are ever shown.
  always_ff @(posedge core_clk) begin
    if (doPush) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  // Pointers wrap naturally because the depth is a power of two.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (doPush) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (doPop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      count_reg <= countNext;
    end
  end

endmodule : otis_fifo

//--- otis_i2c_slave.sv
// Two-wire serial slave giving a bus master access to a register file.
// Assumes core_clk runs far faster than the serial clock, the register
// file answers a read index within one cycle, and pull-ups hold the bus.
// Function
// - Idle bus rests high, slave releases both.
// - Start is SDA falling while SCL high.
// - Stop is SDA rising while SCL high.
// - One data bit per serial clock pulse.
// - SDA changes only while SCL is low.
// - Ninth bit acknowledges, sent by receiver.
// - Slave pulls SDA low through ninth clock.
// - Slave releases ninth clock, samples master acknowledge.
// - Respond only after start and matching address.
// - Address LSB: zero writes, one reads.
// - Upper bits fixed; low bit loaded from strap.
// - Strap low gives zero, high gives one.
// - Further data bytes go to next registers.
// - Read sets index by write, then reads.
// - Index advances after each accepted data byte.
// - Unsupported index: not-acknowledge, index unchanged.
// - Works to 400 kHz, bursts allowed.
`timescale 1ns/100ps
`include "otis_defines.svh"
module otis_i2c_slave #(
  parameter logic [5:0] ADDR_HIGH = `OTIS_ADDR_HIGH,
  parameter logic [7:0] NUM_REGS = `OTIS_NUM_REGS,
  parameter int FIFO_DEPTH = `OTIS_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic sclPin,
  input wire logic sdaPin,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addrSelPin,
  output logic regWrValid,
  input wire logic regWrReady,
  output logic [7:0] regWrIndex,
  output logic [7:0] regWrData,
  output logic [7:0] regRdIndex,
  input wire logic [7:0] regRdData
);

  logic [2:0] pinLevels, strapWait_reg;
  logic sclLevel, sdaLevel, strapLevel, sclPrev_reg, sdaPrev_reg;
  logic sclRise, sclFall, startSeen, stopSeen, quiet;
  otis_pkg::otis_state_type state_reg, ackNext_reg, destState;
  logic [3:0] bitCnt_reg;
  logic [7:0] rxByte_reg, txByte_reg, regIndex_reg;
  logic masterAck_reg, addrLowBit_reg, sdaOe_reg, sdaOut_reg, pushValid_reg;
  logic [15:0] pushData_reg;
  logic fifoInReady, rxState, byteEnd, ackNow, addrMatch, generalCall;
  logic loadTx, readRise, readFall, mackRise;

  // Register indices beyond the implemented file get a not-acknowledge.
  function automatic logic isSupported(input logic [7:0] idx);
    isSupported = (idx < NUM_REGS);
  endfunction : isSupported

  // Clock, data and strap all come from pins and are filtered together.
  otis_pin_sync #(
    .WIDTH(3),
    .RESET_VAL(`OTIS_SYNC_RESET)
  ) uPinSync (
    .core_clk(core_clk),
    .nrst(nrst),
    .pinIn({addrSelPin, sdaPin, sclPin}),
    .pinOut(pinLevels)
  );

  assign sclLevel = pinLevels[0];
  assign sdaLevel = pinLevels[1];
  assign strapLevel = pinLevels[2];

  // Previous filtered levels for edge and condition detection.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else begin
      sclPrev_reg <= sclLevel;
      sdaPrev_reg <= sdaLevel;
    end
  end

  // Edges of the serial clock and the start and stop conditions.
  assign sclRise = sclLevel && !sclPrev_reg;
  assign sclFall = !sclLevel && sclPrev_reg;
  assign startSeen = sclLevel && sclPrev_reg && sdaPrev_reg && !sdaLevel;
  assign stopSeen = sclLevel && sclPrev_reg && !sdaPrev_reg && sdaLevel;
  assign quiet = startSeen || stopSeen;

  // Byte decisions are taken on the falling edge after the eighth bit,
  // so the acknowledge appears only while the clock is low.
  assign rxState = (state_reg == otis_pkg::ST_ADDR) ||
                   (state_reg == otis_pkg::ST_INDEX) ||
                   (state_reg == otis_pkg::ST_WRITE);
  assign byteEnd = !quiet && rxState && sclFall &&
                   (bitCnt_reg == `OTIS_BITS_PER_BYTE);
  assign addrMatch = (rxByte_reg[7:1] == {ADDR_HIGH, addrLowBit_reg});
  assign generalCall = (rxByte_reg == `OTIS_GENERAL_CALL);
  assign readRise = !quiet && (state_reg == otis_pkg::ST_READ) && sclRise;
  assign readFall = !quiet && (state_reg == otis_pkg::ST_READ) && sclFall;
  assign mackRise = !quiet && (state_reg == otis_pkg::ST_MACK) && sclRise;
  assign loadTx = !quiet && sclFall &&
                  (((state_reg == otis_pkg::ST_ACK) &&
                    (ackNext_reg == otis_pkg::ST_READ)) ||
                   ((state_reg == otis_pkg::ST_MACK) && masterAck_reg));

  // Answer to a completed byte and the phase that follows its slot.
  always_comb begin
    ackNow = 1'b0;
    destState = otis_pkg::ST_IDLE;
    case (state_reg)
      otis_pkg::ST_ADDR: begin
        ackNow = addrMatch;
        destState = rxByte_reg[0] ? otis_pkg::ST_READ
                                  : otis_pkg::ST_INDEX;
      end
      otis_pkg::ST_INDEX: begin
        ackNow = 1'b1;
        destState = otis_pkg::ST_WRITE;
      end
      otis_pkg::ST_WRITE: begin
        // A full buffer refuses the byte, so back-pressure reaches the master.
        ackNow = isSupported(regIndex_reg) && fifoInReady;
        destState = otis_pkg::ST_WRITE;
      end
      default: begin
        ackNow = 1'b0;
        destState = otis_pkg::ST_IDLE;
      end
    endcase
  end

  // Phase sequencing; start and stop override any phase.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= otis_pkg::ST_IDLE;
      ackNext_reg <= otis_pkg::ST_IDLE;
    end else if (startSeen) begin
      state_reg <= otis_pkg::ST_ADDR;
    end else if (stopSeen) begin
      state_reg <= otis_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        otis_pkg::ST_ADDR, otis_pkg::ST_INDEX, otis_pkg::ST_WRITE: begin
          if (byteEnd) begin
            ackNext_reg <= destState;
            if (state_reg == otis_pkg::ST_ADDR && !ackNow) begin
              state_reg <= otis_pkg::ST_IGNORE;
            end else begin
              state_reg <= otis_pkg::ST_ACK;
            end
          end
        end
        otis_pkg::ST_ACK: begin
          if (sclFall) begin
            state_reg <= ackNext_reg;
          end
        end
        otis_pkg::ST_READ: begin
          if (sclFall && bitCnt_reg == `OTIS_BITS_PER_BYTE) begin
            state_reg <= otis_pkg::ST_MACK;
          end
        end
        otis_pkg::ST_MACK: begin
          if (sclFall) begin
            // A missing acknowledge ends the read until the next start.
            state_reg <= masterAck_reg ? otis_pkg::ST_READ
                                       : otis_pkg::ST_IGNORE;
          end
        end
        otis_pkg::ST_IDLE, otis_pkg::ST_IGNORE: begin
          state_reg <= state_reg;
        end
        default: begin
          state_reg <= otis_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Bit counting: rises count bits in, every byte slot restarts at zero.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bitCnt_reg <= '0;
    end else if (quiet) begin
      bitCnt_reg <= '0;
    end else if ((rxState || state_reg == otis_pkg::ST_READ) && sclRise &&
                 bitCnt_reg != `OTIS_BITS_PER_BYTE) begin
      bitCnt_reg <= bitCnt_reg + 1'b1;
    end else if (byteEnd || (readFall &&
                 bitCnt_reg == `OTIS_BITS_PER_BYTE)) begin
      bitCnt_reg <= '0;
    end else if (state_reg == otis_pkg::ST_ACK ||
                 state_reg == otis_pkg::ST_MACK) begin
      bitCnt_reg <= '0;
    end
  end

  // Receive shifting on rising edges, most significant bit first.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rxByte_reg <= '0;
    end else if (!quiet && rxState && sclRise &&
                 bitCnt_reg != `OTIS_BITS_PER_BYTE) begin
      rxByte_reg <= {rxByte_reg[6:0], sdaLevel};
    end
  end

  // Transmit byte loads at the slot edge and shifts on each falling edge.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      txByte_reg <= '0;
    end else if (loadTx) begin
      txByte_reg <= regRdData;
    end else if (readFall) begin
      txByte_reg <= {txByte_reg[6:0], 1'b0};
    end
  end

  // The master acknowledge is sampled on the rise of the ninth clock.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      masterAck_reg <= 1'b0;
    end else if (mackRise) begin
      masterAck_reg <= !sdaLevel;
    end
  end

  // Open-drain data drive; released at a start or stop, otherwise changed only just after a falling edge,
  // leaving the whole low phase for the line to settle before the rise.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sdaOe_reg <= 1'b0;
    end else if (quiet) begin
      sdaOe_reg <= 1'b0;
    end else if (byteEnd) begin
      sdaOe_reg <= ackNow;
    end else if (loadTx) begin
      sdaOe_reg <= !regRdData[7];
    end else if (readFall) begin
      if (bitCnt_reg == `OTIS_BITS_PER_BYTE) begin
        sdaOe_reg <= 1'b0;
      end else begin
        sdaOe_reg <= !txByte_reg[6];
      end
    end else if (sclFall && (state_reg == otis_pkg::ST_ACK ||
                             state_reg == otis_pkg::ST_MACK)) begin
      sdaOe_reg <= 1'b0;
    end
  end

  // The driven level is always low; the line is never driven high.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sdaOut_reg <= 1'b0;
    end else begin
      sdaOut_reg <= 1'b0;
    end
  end

  // Register index: set by the index byte, advanced after accepted bytes.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      regIndex_reg <= '0;
    end else if (byteEnd && state_reg == otis_pkg::ST_INDEX) begin
      regIndex_reg <= rxByte_reg;
    end else if (byteEnd && state_reg == otis_pkg::ST_WRITE && ackNow) begin
      regIndex_reg <= regIndex_reg + 1'b1;
    end else if (mackRise && !sdaLevel) begin
      regIndex_reg <= regIndex_reg + 1'b1;
    end
  end

  // Address low bit: caught from the strap once the synchroniser has
  // settled after reset, and again on every general call.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      strapWait_reg <= `OTIS_STRAP_WAIT;
      addrLowBit_reg <= 1'b0;
    end else if (strapWait_reg != '0) begin
      strapWait_reg <= strapWait_reg - 1'b1;
      if (strapWait_reg == 3'h1) begin
        addrLowBit_reg <= strapLevel;
      end
    end else if (byteEnd && state_reg == otis_pkg::ST_ADDR && generalCall) begin
      addrLowBit_reg <= strapLevel;
    end
  end

  // Accepted write bytes leave as one-cycle pushes of index and data.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pushValid_reg <= 1'b0;
      pushData_reg <= '0;
    end else begin
      pushValid_reg <= byteEnd && state_reg == otis_pkg::ST_WRITE && ackNow;
      if (byteEnd) begin
        pushData_reg <= {regIndex_reg, rxByte_reg};
      end
    end
  end

  otis_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) uWrFifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .inValid(pushValid_reg),
    .inReady(fifoInReady),
    .inData(pushData_reg),
    .outValid(regWrValid),
    .outReady(regWrReady),
    .outData({regWrIndex, regWrData})
  );
  // The remaining ports come straight from the flops above.
  assign sdaOe = sdaOe_reg;
  assign sdaOut = sdaOut_reg;
  assign regRdIndex = regIndex_reg;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  a_idle_released: assert property (
    (state_reg == otis_pkg::ST_IDLE) |-> !sdaOe_reg)
    else $error("Data line driven while idle.");
  a_start_addr: assert property (
    startSeen |=> (state_reg == otis_pkg::ST_ADDR) && bitCnt_reg == '0)
    else $error("Start did not open the address phase.");
  a_stop_free: assert property (
    (stopSeen && !startSeen) |=> (state_reg == otis_pkg::ST_IDLE) ##0 !sdaOe_reg)
    else $error("Stop did not free the bus.");
  a_read_bit_count: assert property (
    (readRise && bitCnt_reg != `OTIS_BITS_PER_BYTE)
    |=> bitCnt_reg == $past(bitCnt_reg) + 4'h1)
    else $error("Read bit count did not advance by one.");
  a_change_on_fall: assert property (
    ($changed(sdaOe_reg) && !$past(quiet)) |-> $past(sclFall))
    else $error("Data drive changed away from a falling clock.");
  a_addr_ack: assert property (
    (byteEnd && state_reg == otis_pkg::ST_ADDR && addrMatch)
    |=> sdaOe_reg && state_reg == otis_pkg::ST_ACK)
    else $error("Own address was not acknowledged.");
  a_read_release: assert property (
    (readFall && bitCnt_reg == `OTIS_BITS_PER_BYTE)
    |=> !sdaOe_reg && state_reg == otis_pkg::ST_MACK)
    else $error("Ninth read clock not released.");
  a_unsupported_nack: assert property (
    (byteEnd && state_reg == otis_pkg::ST_WRITE &&
     !isSupported(regIndex_reg))
    |=> !sdaOe_reg && $stable(regIndex_reg) && !pushValid_reg)
    else $error("Unsupported index was acknowledged or moved.");
  a_index_advance: assert property (
    pushValid_reg |-> regIndex_reg == 8'(pushData_reg[15:8] + 8'h1))
    else $error("Index did not follow an accepted byte.");
  a_mismatch_quiet: assert property (
    (state_reg == otis_pkg::ST_IGNORE) |-> !sdaOe_reg)
    else $error("Data line driven after an address mismatch.");
  a_general_call_strap: assert property (
    (byteEnd && state_reg == otis_pkg::ST_ADDR && generalCall &&
     strapWait_reg == '0) |=> addrLowBit_reg == $past(strapLevel))
    else $error("General call did not reload the address bit.");
endmodule : otis_i2c_slave

//--- otis_master_model.sv
// Behavioural two-wire bus master that drives the serial clock and data.
// Assumes pull-ups on both lines; the slave only ever pulls data low.
`timescale 1ns/100ps
module otis_master_model #(
  parameter int TICK_NS = 320
) (
  output logic sclLine,
  output logic sdaDrive,
  input wire logic sdaLine
);
  int unstable = 0;

  // The bus rests high with both lines released.
  initial begin
    sclLine = 1'h1;
    sdaDrive = 1'h1;
  end

  // Start or repeated start: data falls while the clock is high.
  task automatic start_cond;
    #(2 * TICK_NS) sdaDrive = 1'h1;
    #(2 * TICK_NS) sclLine = 1'h1;
    #(4 * TICK_NS) sdaDrive = 1'h0;
    #(4 * TICK_NS) sclLine = 1'h0;
  endtask : start_cond

  // Stop: data rises while the clock is high, freeing the bus.
  task automatic stop_cond;
    #(2 * TICK_NS) sdaDrive = 1'h0;
    #(2 * TICK_NS) sclLine = 1'h1;
    #(4 * TICK_NS) sdaDrive = 1'h1;
    #(4 * TICK_NS);
  endtask : stop_cond

  // One bit per pulse, sampled twice while high to catch a moving line.
  task automatic clock_bit(input logic drv, output logic got);
    logic early;
    #(2 * TICK_NS) sdaDrive = drv;
    #(2 * TICK_NS) sclLine = 1'h1;
    #(TICK_NS) early = sdaLine;
    #(2 * TICK_NS) got = sdaLine;
    if (got !== early) unstable++;
    #(TICK_NS) sclLine = 1'h0;
  endtask : clock_bit

  // Eight bits most significant first, then the slave's answer.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic unused;
    for (int i = 7; i >= 0; i--) clock_bit(b[i], unused);
    clock_bit(1'h1, ack);
  endtask : send_byte

  // Line released for eight bits; the master answers in the ninth.
  task automatic recv_byte(input logic mAck, output logic [7:0] b);
    logic unused;
    for (int i = 7; i >= 0; i--) clock_bit(1'h1, b[i]);
    clock_bit(mAck, unused);
  endtask : recv_byte
endmodule : otis_master_model

//--- testbench.sv
// Self-checking bench for the two-wire slave and its write buffer.
// Assumes the master model and the design files are compiled first.
`timescale 1ns/100ps
`include "otis_defines.svh"
module testbench;
  logic core_clk = 1'h0;
  logic nrst = 1'h0;
  logic sclLine, sdaDrive, sdaOut, sdaOe, regWrValid;
  logic addrSelPin = 1'h0;
  logic regWrReady = 1'h0;
  logic stallAll = 1'h1;
  logic strap, ack;
  logic [7:0] regWrIndex, regWrData, regRdIndex, rd, curIdx;
  logic [7:0] regRdData = 8'h00;
  logic [7:0] mem [32];
  logic [7:0] expReg [32];
  logic [15:0] notes [$];
  int errors = 0;
  int checked = 0;
  wire logic sdaLine;

  // Open drain: the slave can only pull the pulled-up line low.
  assign sdaLine = sdaDrive & ~(sdaOe & ~sdaOut);

  always #20 core_clk = ~core_clk;

  otis_i2c_slave dut (.core_clk(core_clk), .nrst(nrst), .sclPin(sclLine),
    .sdaPin(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addrSelPin(addrSelPin), .regWrValid(regWrValid),
    .regWrReady(regWrReady), .regWrIndex(regWrIndex),
    .regWrData(regWrData), .regRdIndex(regRdIndex),
    .regRdData(regRdData));

  otis_master_model m (.sclLine(sclLine), .sdaDrive(sdaDrive),
    .sdaLine(sdaLine));

  task automatic fail(input string msg);
    errors++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask : fail

  task automatic cmp_bit(input logic got, input logic exp, input string s);
    checked++;
    if (got !== exp) fail(s);
  endtask : cmp_bit

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp,
      input string s);
    checked++;
    if (got !== exp) fail($sformatf("%s %h, want %h", s, got, exp));
  endtask : cmp_byte

  task automatic cmp_entry(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) fail($sformatf("entry %h, want %h", got, exp));
  endtask : cmp_entry

  task automatic close_out;
    if (errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  function automatic logic [7:0] own(input logic rw);
    return {`OTIS_ADDR_HIGH, strap, rw};
  endfunction : own

  // Opens a transfer and checks the answer to the address byte.
  task automatic address(input logic [7:0] a, input logic expAck);
    m.start_cond();
    m.send_byte(a, ack);
    cmp_bit(ack, expAck, "address answer");
  endtask : address

  task automatic wr_index(input logic [7:0] k);
    m.send_byte(k, ack);
    cmp_bit(ack, 1'h0, "index answer");
    curIdx = k;
  endtask : wr_index

  // A refused byte leaves the expected index where it was. The note goes
  // in first, as the buffer may hand the entry on inside the ack slot.
  task automatic wr(input logic [7:0] b, input logic expAck);
    if (expAck == 1'h0) notes.push_back({curIdx, b});
    m.send_byte(b, ack);
    cmp_bit(ack, expAck, "data answer");
    if (expAck == 1'h0) begin
      expReg[curIdx[4:0]] = b;
      curIdx++;
    end
  endtask : wr

  task automatic wait_drain;
    int n = 0;
    while (notes.size() != 0 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    if (notes.size() != 0) fail("write port stalled");
  endtask : wait_drain

  // Register file behind the write port; it stalls always while stallAll is set, else at random.
  always @(posedge core_clk) begin
    #1;
    regWrReady = stallAll ? 1'h0 : 1'($urandom % 2);
    regRdData = mem[regRdIndex[4:0]];
  end

  // Each entry taken by the register file must match the oldest note.
  always @(posedge core_clk) begin
    if (nrst === 1'h1 && regWrValid === 1'h1 && regWrReady === 1'h1) begin
      if (notes.size() == 0) fail("entry without a note");
      else cmp_entry({regWrIndex, regWrData}, notes.pop_front());
      mem[regWrIndex[4:0]] = regWrData;
    end
  end

  // The run should take under two milliseconds of serial traffic.
  initial begin
    #3000000;
    fail("watchdog expired");
    close_out();
  end

  initial begin
    void'($urandom(8750));
    foreach (mem[i]) mem[i] = 8'h00;
    strap = 1'($urandom % 2);
    addrSelPin = strap;
    repeat (3) @(posedge core_clk);
    #1 nrst = 1'h1;
    repeat (10) @(posedge core_clk);
    #1 cmp_bit(sdaOe, 1'h0, "idle release");
    // The other strap address is ignored until the stop.
    address({`OTIS_ADDR_HIGH, ~strap, 1'h0}, 1'h1);
    m.send_byte(8'h03, ack);
    cmp_bit(ack, 1'h1, "ignored byte");
    m.stop_cond();
    // A general call reloads the low address bit from the strap pin.
    @(posedge core_clk);
    #1 addrSelPin = ~strap;
    address(8'h00, 1'h1);
    m.stop_cond();
    address(own(1'h0), 1'h1);
    m.stop_cond();
    strap = ~strap;
    repeat (200) @(posedge core_clk);
    address(own(1'h0), 1'h0);
    // Burst up to the last supported index, then one beyond it.
    wr_index(8'h10);
    for (int i = 0; i < 16; i++) wr(8'($urandom), 1'h0);
    wr(8'h5A, 1'h1);
    m.stop_cond();
    // Fill the buffer until it refuses, drain it, then resume.
    address(own(1'h0), 1'h0);
    wr_index(8'h00);
    for (int i = 0; i < 16; i++) wr(8'($urandom), 1'h0);
    wr(8'hA5, 1'h1);
    stallAll = 1'h0;
    wait_drain();
    wr(8'h3C, 1'h0);
    m.stop_cond();
    wait_drain();
    // Set the index by a write, then read across a repeated start.
    address(own(1'h0), 1'h0);
    wr_index(8'h0E);
    address(own(1'h1), 1'h0);
    for (int i = 0; i < 3; i++) begin
      m.recv_byte(i == 2, rd);
      cmp_byte(rd, expReg[5'(8'h0E + i)], "read data");
    end
    m.stop_cond();
    // A reset in mid-transfer returns to idle with the index cleared.
    address(own(1'h0), 1'h0);
    wr_index(8'h07);
    @(posedge core_clk);
    #1 nrst = 1'h0;
    repeat (2) @(posedge core_clk);
    #1 nrst = 1'h1;
    @(posedge core_clk);
    #1;
    cmp_byte(regRdIndex, 8'h00, "index after reset");
    cmp_bit(sdaOe, 1'h0, "released after reset");
    m.stop_cond();
    address(own(1'h1), 1'h0);
    m.recv_byte(1'h1, rd);
    cmp_byte(rd, expReg[0], "read after reset");
    m.stop_cond();
    cmp_bit(m.unstable == 0, 1'h1, "data moved while clock high");
    close_out();
  end
endmodule : testbench
